// *** bi_defines.svh ***
// Purpose: named constants of the boot and codec init supervisor
// Assumes: 200 MHz reference clock
// Notes: times are kept in their own units; cycle counts are derived
`ifndef BI_DEFINES_SVH
`define BI_DEFINES_SVH
// Clock rate and times
`define BI_CLK_KHZ     200000
`define BI_RST_HOLD_MS 250
`define BI_GAP_MS      50
`define BI_POLL_MS     5
`define BI_PD_MS       2
`define BI_BAUD        9600
`define BI_I2C_KHZ     100
// Widths
`define BI_TMR_W       26
`define BI_QC_W        10
// Failure count that marks a persistent bus fault
`define BI_FAIL_LIMIT  3'h3
// Codec bus address and registers
`define BI_CODEC_ADDR  7'h48
`define BI_ERR_REG     8'h0f
`define BI_INIT_REG0   8'h01
`define BI_INIT_VAL0   8'h00
`define BI_INIT_REG1   8'h02
`define BI_INIT_VAL1   8'h80
// Script item fields and first poll item
`define BI_F_LAST      11
`define BI_F_STOP      10
`define BI_F_START     9
`define BI_F_READ      8
`define BI_SCR_POLL    4'h6
`define BI_ACK_BIT     4'h8
// First burst character
`define BI_CHAR_STAR   8'h2a
`endif

// *** bi_pkg.sv ***
// Purpose: types of the boot and codec init supervisor
// Assumes: bi_defines.svh on the include path
// Notes: none
`include "bi_defines.svh"
package bi_pkg;
  typedef enum logic [3:0] {
    M_RST, M_BURST1, M_GAP, M_PROMPT, M_PD, M_INIT, M_WAIT, M_POLL, M_ERR
  } bi_main_t;
  typedef enum logic [1:0] {I_IDLE, I_STA, I_BIT, I_STO} bi_i2c_t;
  typedef enum logic [1:0] {MSG_STARS, MSG_PROMPT, MSG_ERR} bi_msg_t;
  typedef logic [`BI_TMR_W-1:0] bi_tmr_t;
  typedef logic [`BI_QC_W-1:0]  bi_qc_t;
endpackage

// *** bi_uart_tx.sv ***
// Purpose: 8N1 serial transmitter for the debug output
// Assumes: start_i only while busy_o is low
// Notes: line idles high
`timescale 1ns/1ps
module bi_uart_tx #(
  parameter int unsigned DIV = 20833
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Byte request
  input  wire logic       start_i,
  input  wire logic [7:0] data_i,
  output logic            busy_o,
  // Serial line
  output logic            tx_o
);
  logic [15:0] div_q, div_d;  // Bit period counter
  logic [3:0]  bit_q, bit_d;  // Steps left, zero when idle
  logic [9:0]  sh_q, sh_d;    // Frame shifter
  logic        tx_q, tx_d;    // Line level

  // Next frame state
  always_comb begin
    div_d = div_q;
    bit_d = bit_q;
    sh_d  = sh_q;
    tx_d  = tx_q;
    if (start_i && bit_q == 4'h0) begin
      sh_d  = {1'b1, data_i, 1'b0};
      bit_d = 4'hb;
      div_d = 16'h0;
    end else if (bit_q != 4'h0) begin
      if (div_q == 16'h0) begin
        // Next bit onto the line, ones fill behind
        tx_d  = sh_q[0];
        sh_d  = {1'b1, sh_q[9:1]};
        bit_d = bit_q - 4'h1;
        div_d = 16'(DIV - 1);
      end else begin
        div_d = div_q - 16'h1;
      end
    end
  end

  // Frame registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= 16'h0;
      bit_q <= 4'h0;
      sh_q  <= 10'h3ff;
      tx_q  <= 1'b1;
    end else begin
      div_q <= div_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      tx_q  <= tx_d;
    end
  end

  assign busy_o = (bit_q != 4'h0);
  assign tx_o   = tx_q;

  idle_high_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !busy_o |-> tx_o) else $error("serial line low while idle");
endmodule // bi_uart_tx

// *** bi_boot_supervisor.sv ***
// Purpose: power-up supervisor: reset hold, boot prompt, 3.3 V enable,
//          codec reset, init and polling over a two-wire bus, mutes
// Assumes: 200 MHz ref_clk_i; bus pins are open drain, enable pulls low
// Notes: a supply drop at any time restarts the whole sequence
`timescale 1ns/1ps
`include "bi_defines.svh"
// Notes on behaviour
// - two asterisks right after reset release
// - boot prompt about 50 ms later
// - afterwards debug output carries only error codes
// - hold reset 250 ms after supply stable
// - runs from a stable reference clock
// - 3.3 V inhibited until boot succeeds
// - pulse codec power-down low a few ms
// - write codec configuration registers over bus
// - read codec error status every 5 ms
// - persistent bus failure sends error code
// - detect low means digital input present
// - three mute lines, low mutes group
module bi_boot_supervisor #(
  parameter int unsigned RST_HOLD = `BI_RST_HOLD_MS * `BI_CLK_KHZ,
  parameter int unsigned GAP      = `BI_GAP_MS * `BI_CLK_KHZ,
  parameter int unsigned POLL     = `BI_POLL_MS * `BI_CLK_KHZ,
  parameter int unsigned PD       = `BI_PD_MS * `BI_CLK_KHZ,
  parameter int unsigned BAUD_DIV = `BI_CLK_KHZ * 1000 / `BI_BAUD,
  parameter int unsigned QTR      = `BI_CLK_KHZ / (`BI_I2C_KHZ * 4), // Quarter bus bit
  parameter logic [55:0] PROMPT   = "#BOOT01", // Arbitrary prompt value
  parameter logic [15:0] ERR_CODE = "!E"       // Arbitrary error code
) (
  // Clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  // Board pins in
  input  wire logic       supply_ok_i,
  input  wire logic       dig_detect_n_i,
  input  wire logic       sda_i,
  input  wire logic [2:0] unmute_req_i,
  // Supervisory outputs
  output logic            ctrl_rst_n_o,
  output logic            debug_serial_out_o,
  output logic            reg_inhibit_o,
  output logic            codec_pd_n_o,
  output logic [2:0]      amp_unmute_o,
  output logic            dig_in_present_o,
  output logic [7:0]      codec_status_o,
  output logic            i2c_fault_o,
  // Two-wire bus pins
  output logic            scl_o,
  output logic            scl_oe_o,
  output logic            sda_o,
  output logic            sda_oe_o
);
  localparam logic [2:0]  PLEN = 3'($bits(PROMPT) / 8);
  localparam logic [2:0]  ELEN = 3'($bits(ERR_CODE) / 8);

  logic [2:0] s1_q, s2_q;           // Pin synchroniser {sda, det_n, sup}
  bi_pkg::bi_main_t st_q, st_d;     // Sequence state
  bi_pkg::bi_tmr_t  tmr_q, tmr_d;   // Shared down timer
  bi_pkg::bi_msg_t  msg_q, msg_d;   // Message being sent
  logic [2:0] pos_q, pos_d;         // Characters sent
  logic crst_n_q, crst_n_d;         // Controller reset line
  logic inh_q, inh_d;               // Regulator inhibit
  logic pd_n_q, pd_n_d;             // Codec power-down
  logic done_q, done_d;             // Codec initialised
  logic [2:0] fail_q, fail_d;       // Consecutive bus failures
  logic flt_q, flt_d;               // Persistent fault
  logic sent_q, sent_d;             // Error code already sent
  logic [7:0] stat_q, stat_d;       // Last error status read
  logic [2:0] mute_q, mute_d;       // Mute lines
  logic det_q, det_d;               // Digital input present
  bi_pkg::bi_i2c_t ist_q, ist_d;    // Bus engine state
  logic [1:0] q_q, q_d;             // Quarter bit phase
  bi_pkg::bi_qc_t qc_q, qc_d;       // Quarter bit counter
  logic [3:0] b_q, b_d;             // Bit in byte, 8 is ack
  logic [7:0] sh_q, sh_d;           // Byte shifter
  logic [3:0] idx_q, idx_d;         // Script item
  logic scl_oe_q, scl_oe_d;         // Clock pulled low
  logic sda_oe_q, sda_oe_d;         // Data pulled low
  logic nack_q, nack_d;             // Missing ack in transfer
  logic sup_ok, det_n, sda_s;       // Synchronised pins
  logic tx_go, tx_busy, xdone, adv; // Strobes
  logic txing, mfin, run;
  logic [2:0] mlen;
  logic [7:0] chr;
  logic [11:0] item, nxt;

  // Bus script: {last, stop, start, read, byte}
  function automatic logic [11:0] scr(input logic [3:0] i);
    case (i)
      4'h0:    scr = {4'h2, `BI_CODEC_ADDR, 1'b0};
      4'h1:    scr = {4'h0, `BI_INIT_REG0};
      4'h2:    scr = {4'h4, `BI_INIT_VAL0};
      4'h3:    scr = {4'h2, `BI_CODEC_ADDR, 1'b0};
      4'h4:    scr = {4'h0, `BI_INIT_REG1};
      4'h5:    scr = {4'hc, `BI_INIT_VAL1};
      4'h6:    scr = {4'h2, `BI_CODEC_ADDR, 1'b0};
      4'h7:    scr = {4'h4, `BI_ERR_REG};
      4'h8:    scr = {4'h2, `BI_CODEC_ADDR, 1'b1};
      default: scr = {4'hd, 8'hff};
    endcase
  endfunction

  // Two flip-flops ahead of the data, detect and supply pin logic; unmute_req_i is not synchronised
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 3'h6;
      s2_q <= 3'h6;
    end else begin
      s1_q <= {sda_i, dig_detect_n_i, supply_ok_i};
      s2_q <= s1_q;
    end
  end
  assign {sda_s, det_n, sup_ok} = s2_q;

  // Message length and current character
  always_comb begin
    case (msg_q)
      bi_pkg::MSG_STARS: begin
        mlen = 3'h2;
        chr  = `BI_CHAR_STAR;
      end
      bi_pkg::MSG_PROMPT: begin
        mlen = PLEN;
        chr  = PROMPT[8*(PLEN-1-pos_q) +: 8];
      end
      default: begin
        mlen = ELEN;
        chr  = ERR_CODE[8*(ELEN-1-pos_q) +: 8];
      end
    endcase
  end
  assign txing = (st_q == bi_pkg::M_BURST1) || (st_q == bi_pkg::M_PROMPT) ||
                 (st_q == bi_pkg::M_ERR);
  assign mfin  = txing && (pos_q == mlen) && !tx_busy;
  assign tx_go = txing && (pos_q != mlen) && !tx_busy;
  assign run   = (st_q == bi_pkg::M_INIT) || (st_q == bi_pkg::M_POLL);
  assign item  = scr(idx_q);
  assign nxt   = scr(idx_q + 4'h1);

  // Next state of sequence and bus engine
  always_comb begin
    st_d = st_q;  tmr_d = tmr_q;  msg_d = msg_q;  pos_d = pos_q;
    crst_n_d = crst_n_q;  inh_d = inh_q;  pd_n_d = pd_n_q;
    done_d = done_q;  fail_d = fail_q;  flt_d = flt_q;  sent_d = sent_q;
    stat_d = stat_q;  ist_d = ist_q;  q_d = q_q;  qc_d = qc_q;  b_d = b_q;
    sh_d = sh_q;  idx_d = idx_q;  scl_oe_d = scl_oe_q;  sda_oe_d = sda_oe_q;
    nack_d = nack_q;  xdone = 1'b0;  adv = 1'b0;
    det_d = !det_n;
    // groups stay muted until the codec is up
    mute_d = done_q ? unmute_req_i : 3'h0;
    if (tx_go) begin
      pos_d = pos_q + 3'h1;
    end
    if (run) begin
      if (ist_q == bi_pkg::I_IDLE) begin
        ist_d  = item[`BI_F_START] ? bi_pkg::I_STA : bi_pkg::I_BIT;
        sh_d   = item[7:0];
        b_d    = 4'h0;
        q_d    = 2'h0;
        nack_d = 1'b0;
        qc_d   = bi_pkg::bi_qc_t'(QTR - 1);
      end else if (qc_q != '0) begin
        qc_d = qc_q - 1'b1;
      end else begin
        qc_d = bi_pkg::bi_qc_t'(QTR - 1);
        q_d  = q_q + 2'h1;
        case (ist_q)
          bi_pkg::I_STA: begin
            // Data falls while the clock is high
            if (q_q == 2'h0) begin
              sda_oe_d = 1'b0;
              scl_oe_d = 1'b0;
            end else if (q_q == 2'h2) begin
              sda_oe_d = 1'b1;
            end else if (q_q == 2'h3) begin
              scl_oe_d = 1'b1;
              ist_d    = bi_pkg::I_BIT;
            end
          end
          bi_pkg::I_BIT: begin
            if (q_q == 2'h0) begin
              sda_oe_d = (b_q < `BI_ACK_BIT) && !item[`BI_F_READ] && !sh_q[7];
            end else if (q_q == 2'h1) begin
              scl_oe_d = 1'b0;
            end else if (q_q == 2'h2) begin
              // Shift out and in together; ack bit checks the codec
              if (b_q < `BI_ACK_BIT) begin
                sh_d = {sh_q[6:0], sda_s};
              end else if (!item[`BI_F_READ] && sda_s) begin
                nack_d = 1'b1;
              end
            end else begin
              scl_oe_d = 1'b1;
              b_d      = b_q + 4'h1;
              if (b_q == `BI_ACK_BIT) begin
                if (item[`BI_F_STOP]) begin
                  ist_d = bi_pkg::I_STO;
                end else begin
                  adv = 1'b1;
                end
              end
            end
          end
          bi_pkg::I_STO: begin
            // Data rises while the clock is high
            if (q_q == 2'h0) begin
              sda_oe_d = 1'b1;
            end else if (q_q == 2'h1) begin
              scl_oe_d = 1'b0;
            end else if (q_q == 2'h2) begin
              sda_oe_d = 1'b0;
            end else if (item[`BI_F_LAST]) begin
              ist_d = bi_pkg::I_IDLE;
              xdone = 1'b1;
            end else begin
              adv = 1'b1;
            end
          end
          default: ist_d = bi_pkg::I_IDLE;
        endcase
        if (adv) begin
          idx_d = idx_q + 4'h1;
          sh_d  = nxt[7:0];
          b_d   = 4'h0;
          ist_d = nxt[`BI_F_START] ? bi_pkg::I_STA : bi_pkg::I_BIT;
        end
      end
    end
    // Sequence
    case (st_q)
      bi_pkg::M_RST: begin
        crst_n_d = 1'b0;
        if (tmr_q == '0) begin
          crst_n_d = 1'b1;
          st_d     = bi_pkg::M_BURST1;
          msg_d    = bi_pkg::MSG_STARS;
          pos_d    = 3'h0;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      bi_pkg::M_BURST1: begin
        if (mfin) begin
          st_d  = bi_pkg::M_GAP;
          tmr_d = bi_pkg::bi_tmr_t'(GAP - 1);
        end
      end
      bi_pkg::M_GAP: begin
        if (tmr_q == '0) begin
          st_d  = bi_pkg::M_PROMPT;
          msg_d = bi_pkg::MSG_PROMPT;
          pos_d = 3'h0;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      bi_pkg::M_PROMPT: begin
        if (mfin) begin
          // boot done, ground the inhibit node
          inh_d  = 1'b0;
          pd_n_d = 1'b0;
          st_d   = bi_pkg::M_PD;
          tmr_d  = bi_pkg::bi_tmr_t'(PD - 1);
        end
      end
      bi_pkg::M_PD: begin
        // init follows the end of the pulse
        if (tmr_q == '0) begin
          pd_n_d = 1'b1;
          st_d   = bi_pkg::M_INIT;
          idx_d  = 4'h0;
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      bi_pkg::M_WAIT: begin
        // poll period; retry init while not done
        if (tmr_q == '0) begin
          if (done_q) begin
            st_d  = bi_pkg::M_POLL;
            idx_d = `BI_SCR_POLL;
          end else begin
            pd_n_d = 1'b0;
            st_d   = bi_pkg::M_PD;
            tmr_d  = bi_pkg::bi_tmr_t'(PD - 1);
          end
        end else begin
          tmr_d = tmr_q - 1'b1;
        end
      end
      bi_pkg::M_INIT, bi_pkg::M_POLL: begin
        if (xdone) begin
          st_d  = bi_pkg::M_WAIT;
          tmr_d = bi_pkg::bi_tmr_t'(POLL - 1);
          if (!nack_q) begin
            fail_d = 3'h0;
            flt_d  = 1'b0;
            sent_d = 1'b0;
            if (st_q == bi_pkg::M_INIT) begin
              done_d = 1'b1;
            end else begin
              stat_d = sh_q;
            end
          end else begin
            if (fail_q != `BI_FAIL_LIMIT) begin
              fail_d = fail_q + 3'h1;
            end
            if (fail_q + 3'h1 >= `BI_FAIL_LIMIT) begin
              flt_d = 1'b1;
              if (!sent_q) begin
                sent_d = 1'b1;
                st_d   = bi_pkg::M_ERR;
                msg_d  = bi_pkg::MSG_ERR;
                pos_d  = 3'h0;
              end
            end
          end
        end
      end
      bi_pkg::M_ERR: begin
        if (mfin) begin
          st_d  = bi_pkg::M_WAIT;
          tmr_d = bi_pkg::bi_tmr_t'(POLL - 1);
        end
      end
      default: st_d = bi_pkg::M_RST;
    endcase
    // supply loss restarts; regulator off again
    if (!sup_ok) begin
      st_d = bi_pkg::M_RST;  tmr_d = bi_pkg::bi_tmr_t'(RST_HOLD - 1);
      crst_n_d = 1'b0;  inh_d = 1'b1;  pd_n_d = 1'b1;  done_d = 1'b0;
      ist_d = bi_pkg::I_IDLE;  scl_oe_d = 1'b0;  sda_oe_d = 1'b0;
    end
  end

  // Sequence and bus registers
  // one reference clock drives all
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= bi_pkg::M_RST;  tmr_q <= bi_pkg::bi_tmr_t'(RST_HOLD - 1);
      msg_q <= bi_pkg::MSG_STARS;  pos_q <= 3'h0;  crst_n_q <= 1'b0;
      inh_q <= 1'b1;  pd_n_q <= 1'b1;  done_q <= 1'b0;  fail_q <= 3'h0;
      flt_q <= 1'b0;  sent_q <= 1'b0;  stat_q <= 8'h0;  mute_q <= 3'h0;
      det_q <= 1'b0;  ist_q <= bi_pkg::I_IDLE;  q_q <= 2'h0;  qc_q <= '0;
      b_q <= 4'h0;  sh_q <= 8'h0;  idx_q <= 4'h0;  scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;  nack_q <= 1'b0;
    end else begin
      st_q <= st_d;  tmr_q <= tmr_d;  msg_q <= msg_d;  pos_q <= pos_d;
      crst_n_q <= crst_n_d;  inh_q <= inh_d;  pd_n_q <= pd_n_d;
      done_q <= done_d;  fail_q <= fail_d;  flt_q <= flt_d;
      sent_q <= sent_d;  stat_q <= stat_d;  mute_q <= mute_d;
      det_q <= det_d;  ist_q <= ist_d;  q_q <= q_d;  qc_q <= qc_d;
      b_q <= b_d;  sh_q <= sh_d;  idx_q <= idx_d;  scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;  nack_q <= nack_d;
    end
  end

  // Debug serial transmitter
  bi_uart_tx #(.DIV(BAUD_DIV)) u_tx (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (tx_go),
    .data_i    (chr),
    .busy_o    (tx_busy),
    .tx_o      (debug_serial_out_o)
  );

  // Outputs
  assign ctrl_rst_n_o     = crst_n_q;
  assign reg_inhibit_o    = inh_q;
  assign codec_pd_n_o     = pd_n_q;
  assign amp_unmute_o     = mute_q;
  assign dig_in_present_o = det_q;
  assign codec_status_o   = stat_q;
  assign i2c_fault_o      = flt_q;
  assign scl_o            = 1'b0;
  assign sda_o            = 1'b0;
  assign scl_oe_o         = scl_oe_q;
  assign sda_oe_o         = sda_oe_q;

  // Helper: cycles of stable supply
  bi_pkg::bi_tmr_t ok_cnt_q;
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ok_cnt_q <= '0;
    end else begin
      ok_cnt_q <= !sup_ok ? '0 : (&ok_cnt_q ? ok_cnt_q : ok_cnt_q + 1'b1);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  stars_first_a: assert property ($rose(ctrl_rst_n_o) |-> tx_go && chr == `BI_CHAR_STAR)
    else $error("first burst not started at reset release");
  prompt_after_gap_a: assert property ($rose(st_q == bi_pkg::M_PROMPT) |->
    $past(st_q) == bi_pkg::M_GAP && $past(tmr_q) == '0 && tx_go)
    else $error("prompt not sent after the gap");
  quiet_line_a: assert property (tx_go |->
    txing && (!done_q || msg_q == bi_pkg::MSG_ERR))
    else $error("serial traffic outside a message");
  reset_hold_a: assert property ($rose(ctrl_rst_n_o) |-> ok_cnt_q >= RST_HOLD)
    else $error("reset released too early");
  inhibit_boot_a: assert property (!ctrl_rst_n_o || st_q inside {bi_pkg::M_BURST1,
    bi_pkg::M_GAP, bi_pkg::M_PROMPT} |-> reg_inhibit_o)
    else $error("regulator enabled before boot");
  pd_pulse_a: assert property ($fell(codec_pd_n_o) |-> ##1 !codec_pd_n_o [*8])
    else $error("codec power-down pulse too short");
  init_after_pd_a: assert property ($rose(codec_pd_n_o) |-> st_q == bi_pkg::M_INIT)
    else $error("init did not follow power-down pulse");
  poll_ready_a: assert property (st_q == bi_pkg::M_POLL |-> done_q && codec_pd_n_o)
    else $error("polling before init");
  poll_period_a: assert property ($rose(st_q == bi_pkg::M_POLL) |->
    $past(st_q) == bi_pkg::M_WAIT && $past(tmr_q) == '0)
    else $error("poll not timed by the wait");
  err_report_a: assert property ($rose(st_q == bi_pkg::M_ERR) |-> ##1 i2c_fault_o)
    else $error("error code without fault flag");
  detect_a: assert property (dig_in_present_o == !$past(dig_detect_n_i, 3))
    else $error("digital input detect wrong");
  mute_a: assert property (!done_q && !$past(done_q) |-> amp_unmute_o == 3'h0)
    else $error("amplifier unmuted before init");

  boot_c: cover property ($fell(reg_inhibit_o));
  poll_c: cover property (st_q == bi_pkg::M_POLL && xdone && !nack_q);
  err_c:  cover property ($rose(st_q == bi_pkg::M_ERR));
  retry_c: cover property (st_q == bi_pkg::M_WAIT && !done_q && tmr_q == '0);
endmodule // bi_boot_supervisor

// *** bi_codec_model.sv ***
// Purpose: behavioural codec on the two-wire bus
// Assumes: wires pulled up, sda_oe_o high pulls data low
// Notes: logs written data bytes, answers reads with stat_i
`timescale 1ns/1ps
`include "bi_defines.svh"
module bi_codec_model (
  // Bus wires
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  // Codec control
  input  wire logic       pd_n_i,
  input  wire logic       ack_en_i,
  input  wire logic [7:0] stat_i,
  output logic            sda_oe_o
);
  int         n     = 0;     // Bit count in byte
  logic       act   = 1'b0;  // Transfer open
  logic       first = 1'b0;  // Address byte
  logic       rd    = 1'b0;  // Read transfer
  logic       hit   = 1'b0;  // Addressed and acking
  logic [7:0] sh    = 8'h00; // Shift register
  logic [7:0] wr[$];         // Written data bytes
  logic       bclk  = 1'b0;  // Audio bit clock
  logic       fclk  = 1'b0;  // Audio frame clock
  int         bn    = 0;     // Bit clocks seen
  logic       err_pin;       // Receive error indication
  initial sda_oe_o = 1'b0;
  // audio clocks run once powered and configured
  always #44.29 if (pd_n_i && wr.size() >= 4) bclk = !bclk;
  always @(negedge bclk) begin
    bn++;
    if (bn % 128 == 0) fclk = !fclk;
  end
  // no receive errors here, so the pin stays low
  assign err_pin = 1'b0;
  always @(negedge sda_i) if (scl_i && pd_n_i) begin
    n = 0;
    act = 1'b1;
    first = 1'b1;
  end
  // Stop releases the data wire
  always @(posedge sda_i) if (scl_i) begin
    act = 1'b0;
    sda_oe_o = 1'b0;
  end
  // Sample bits on rising clock
  always @(posedge scl_i) if (act) begin
    if (n < 8) sh = {sh[6:0], sda_i};
    // A nack from the master ends a read, so let go of the wire
    if (n == 8 && rd && !first && sda_i) hit = 1'b0;
    n++;
  end
  // Drive ack and read data while clock low
  always @(negedge scl_i) if (act) begin
    if (n == 9) begin
      n = 0;
      first = 1'b0;
    end
    if (n == 8 && first) begin
      rd = sh[0];
      hit = sh[7:1] == `BI_CODEC_ADDR && ack_en_i;
    end else if (n == 8 && !rd && hit) wr.push_back(sh);
    if (n == 8) sda_oe_o = hit && (first || !rd);
    else sda_oe_o = hit && rd && !first && !stat_i[7-n];
  end
endmodule // bi_codec_model

// *** bi_boot_supervisor_tb.sv ***
// Purpose: self-checking bench of the boot supervisor
// Assumes: shortened counts, 200 MHz clock
// Notes: debug line decoded at BD cycles a bit
`timescale 1ns/1ps
`include "bi_defines.svh"
module bi_boot_supervisor_tb;
  localparam int BD = 16; // Bit period
  localparam int GP = 300; // Gap count
  localparam logic [55:0] PR = "#BOOT01"; // Arbitrary prompt
  logic ref_clk_i = 0, rst_i = 1, supply_ok_i = 0, dig_detect_n_i = 1, ack_en = 1;
  logic [2:0] unmute_req_i = 3'h0, amp_unmute_o;
  logic [7:0] stat = 8'h00, codec_status_o, b, ex[$];
  logic ctrl_rst_n_o, debug_serial_out_o, reg_inhibit_o, codec_pd_n_o, dig_in_present_o;
  logic i2c_fault_o, scl_o, scl_oe_o, sda_o, sda_oe_o, cod_oe;
  wire scl = !scl_oe_o; // Pull-up wires
  wire sda = !(sda_oe_o | cod_oe);
  // regulator runs only while its inhibit is grounded
  wire rail_on = !reg_inhibit_o;
  int mismatches = 0, comparisons = 0, seed = 28269, cyc = 0, t0, t1, k;
  int st[$];
  byte ch[$];
  always #2.5 ref_clk_i = !ref_clk_i;
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  bi_boot_supervisor #(.RST_HOLD(200), .GAP(GP), .POLL(3000), .PD(50), .BAUD_DIV(BD),
    .QTR(8), .PROMPT(PR)) bi_boot_supervisor_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .supply_ok_i(supply_ok_i), .dig_detect_n_i(dig_detect_n_i), .sda_i(sda),
    .unmute_req_i(unmute_req_i), .ctrl_rst_n_o(ctrl_rst_n_o),
    .debug_serial_out_o(debug_serial_out_o), .reg_inhibit_o(reg_inhibit_o),
    .codec_pd_n_o(codec_pd_n_o), .amp_unmute_o(amp_unmute_o),
    .dig_in_present_o(dig_in_present_o), .codec_status_o(codec_status_o),
    .i2c_fault_o(i2c_fault_o), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o));
  bi_codec_model bi_codec_model_inst (.scl_i(scl), .sda_i(sda), .pd_n_i(codec_pd_n_o),
    .ack_en_i(ack_en), .stat_i(stat), .sda_oe_o(cod_oe));
  // Compare and count
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Verdict and stop
  task end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Decode debug characters at mid bit
  initial forever begin
    @(negedge debug_serial_out_o);
    st.push_back(cyc);
    repeat (BD / 2) @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BD) @(posedge ref_clk_i);
      b[i] = debug_serial_out_o;
    end
    repeat (BD) @(posedge ref_clk_i);
    ch.push_back(b);
  end
  // Cut a hang short
  initial begin
    repeat (60000) @(posedge ref_clk_i);
    mismatches++;
    end_of_test;
  end
  initial begin
    ex = '{8'h2a, 8'h2a, PR[55:48], PR[47:40], PR[39:32], PR[31:24], PR[23:16], PR[15:8],
      PR[7:0], 8'h21, 8'h45};
    stat = 8'($random(seed)) | 8'h01;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 0;
    unmute_req_i <= 3'($random(seed)) | 3'h1;
    repeat (3) @(posedge ref_clk_i);
    chk("inhibit_rst", 1, reg_inhibit_o);
    supply_ok_i <= 1;
    for (k = 0; k < 3000 && ch.size() < 2; k++) @(posedge ref_clk_i);
    supply_ok_i <= 0;
    repeat (5) @(posedge ref_clk_i);
    chk("rst_drop", 0, ctrl_rst_n_o);
    chk("inhibit_drop", 1, reg_inhibit_o);
    chk("rail_off", 0, rail_on);
    ch.delete();
    st.delete();
    supply_ok_i <= 1;
    t0 = cyc;
    for (k = 0; k < 3000 && ctrl_rst_n_o !== 1'b1; k++) @(posedge ref_clk_i);
    chk("hold", 1, cyc - t0 >= 200 && cyc - t0 <= 205);
    t1 = cyc;
    for (k = 0; k < 5000 && ch.size() < 9; k++) @(posedge ref_clk_i);
    chk("star_lag", 1, st.size() > 2 && st[0] - t1 <= 3);
    chk("gap", 1, st.size() > 2 && st[2] - st[1] >= 10 * BD + GP);
    chk("gap_max", 1, st.size() > 2 && st[2] - st[1] <= 10 * BD + GP + 10);
    for (k = 0; k < 500 && codec_pd_n_o !== 1'b0; k++) @(posedge ref_clk_i);
    chk("inhibit_on", 0, reg_inhibit_o);
    chk("rail_on", 1, rail_on);
    t0 = cyc;
    while (codec_pd_n_o === 1'b0 && cyc - t0 < 500) begin
      chk("bus_in_pd", 0, scl_oe_o);
      @(posedge ref_clk_i);
    end
    chk("pd_len", 1, cyc - t0 >= 50 && cyc - t0 <= 52);
    chk("mute_pre", 0, amp_unmute_o);
    for (k = 0; k < 20000 && codec_status_o !== stat; k++) @(posedge ref_clk_i);
    chk("status", stat, codec_status_o);
    ex[9] = `BI_INIT_REG0;
    ex[10] = `BI_INIT_VAL0;
    ex.push_back(`BI_INIT_REG1);
    ex.push_back(`BI_INIT_VAL1);
    ex.push_back(`BI_ERR_REG);
    for (int i = 0; i < 5; i++) chk("wr", ex[9+i], bi_codec_model_inst.wr[i]);
    for (int i = 0; i < 6; i++) begin
      unmute_req_i <= 3'($random(seed));
      dig_detect_n_i <= 1'($random(seed));
      repeat (5) @(posedge ref_clk_i);
      chk("unmute", unmute_req_i, amp_unmute_o);
      chk("present", !dig_detect_n_i, dig_in_present_o);
    end
    chk("quiet", 9, ch.size());
    ex[9] = 8'h21;
    ex[10] = 8'h45;
    for (int i = 0; i < 9; i++) chk("boot_char", ex[i], ch[i]);
    ack_en <= 0;
    for (k = 0; k < 30000 && ch.size() < 11; k++) @(posedge ref_clk_i);
    chk("fault", 1, i2c_fault_o);
    for (int i = 9; i < 11; i++) chk("err_char", ex[i], ch[i]);
    end_of_test;
  end
endmodule // bi_boot_supervisor_tb
